// ---- hw/frnm_core.v ----
// Fractional-N divide value modulator: ramp engine, keying, slip reduction
`timescale 1ns/1ps
`default_nettype none
`include "frnm_map.vh"

module frnm_core (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Avalon-MM slave
	input wire [5:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	// Pins
	input wire ref_in,
	input wire mod_data,
	input wire slip_imminent,
	input wire freq_passed,
	// Divide value and analog controls
	output reg [15:0] div_int,
	output reg [24:0] div_frac,
	output reg phase_flip,
	output reg [6:0] slip_cells,
	output reg pc_tick,
	output reg ramp_active
);

	localparam ST_IDLE = 4'b0001;
	localparam ST_RUN = 4'b0010;
	localparam ST_RESTORE = 4'b0100;
	localparam ST_HOLD = 4'b1000;

	// Zero divider counts as one
	function [11:0] nz12;
		input [11:0] v;
		begin
			nz12 = (v == 12'h000) ? 12'h001 : v;
		end
	endfunction

	// Signed hop word shifted into the 41-bit divide value
	function [40:0] hop_ext;
		input [15:0] w;
		input [3:0] s;
		begin
			hop_ext = {{25{w[15]}}, w} << s;
		end
	endfunction

	reg [31:0] intfrac_r, lsbfrac_r, rdiv_r, func_r, test_r, delay_r;
	reg [15:0] hop0_r, hop1_r;
	reg [3:0] shift0_r, shift1_r;
	reg [19:0] steps0_r, steps1_r;
	reg start_r;
	reg [2:0] ref_s, mod_s, slip_s, pass_s;
	reg ref_d, slip_d, pass_d;
	reg [11:0] rcnt_r;
	reg halve_t;
	reg [11:0] cnt_a, cnt_b;
	reg [19:0] step_cnt;
	reg dir_down;
	reg [3:0] state;
	reg [40:0] acc;
	reg [2:0] cells;
	reg overshoot;
	reg [31:0] rd_nxt;
	reg [40:0] out_nxt;
	wire req;
	wire [3:0] idx;
	wire [40:0] base;
	wire [1:0] mode;
	wire slip_en;
	wire ref_edge;
	wire [11:0] rdiv;
	wire pc_en;
	wire hop_due;
	wire [19:0] leg_steps;

	assign req = avs_read | avs_write;
	assign idx = avs_address[5:2];
	assign base = {intfrac_r[`FRNM_INT_MSB:`FRNM_INT_LSB],
		intfrac_r[`FRNM_FMSB_MSB:`FRNM_FMSB_LSB],
		lsbfrac_r[`FRNM_FLSB_MSB:`FRNM_FLSB_LSB]};
	assign mode = func_r[`FRNM_MODE_MSB:`FRNM_MODE_LSB];
	assign slip_en = rdiv_r[`FRNM_SLIP_EN_BIT];
	assign rdiv = nz12({7'h00, rdiv_r[`FRNM_RCNT_MSB:`FRNM_RCNT_LSB]});
	// Doubler adds falling edges to the count
	assign ref_edge = (ref_s[2] & ~ref_d) | (rdiv_r[`FRNM_DOUBLE_BIT] & ~ref_s[2] & ref_d);
	assign pc_en = ref_edge && (rcnt_r == rdiv - 12'h001) &&
		(~rdiv_r[`FRNM_HALVE_BIT] | halve_t);
	assign hop_due = pc_en && (cnt_a == nz12(rdiv_r[`FRNM_DIVA_MSB:`FRNM_DIVA_LSB]) - 12'h001) &&
		(cnt_b == nz12(test_r[`FRNM_DIVB_MSB:`FRNM_DIVB_LSB]) - 12'h001);
	// Down leg of the triangle counts the second step set
	assign leg_steps = dir_down ? steps1_r : steps0_r;

	// Register read mux
	always @* begin
		case (idx)
			`FRNM_IDX_INTFRAC: rd_nxt = intfrac_r;
			`FRNM_IDX_LSBFRAC: rd_nxt = lsbfrac_r;
			`FRNM_IDX_RDIV: rd_nxt = rdiv_r;
			`FRNM_IDX_FUNC: rd_nxt = func_r;
			`FRNM_IDX_TEST: rd_nxt = test_r;
			`FRNM_IDX_DEVI: rd_nxt = {9'h000, shift0_r, hop0_r, 3'h5};
			`FRNM_IDX_STEP: rd_nxt = {9'h000, steps0_r, 3'h6};
			`FRNM_IDX_DELAY: rd_nxt = delay_r;
			`FRNM_IDX_STAT_FRAC: rd_nxt = {7'h00, div_frac};
			`FRNM_IDX_STAT_INT: rd_nxt = {16'h0000, div_int};
			`FRNM_IDX_STAT_MISC: rd_nxt = {24'h000000, state, overshoot, cells};
			default: rd_nxt = 32'h00000000;
		endcase
	end

	// Keying on top of the ramp value
	always @* begin
		out_nxt = acc;
		if (func_r[`FRNM_FSK_BIT]) begin
			if (mod_s[2])
				out_nxt = acc + hop_ext(hop1_r, shift1_r);
			else
				out_nxt = acc - hop_ext(hop1_r, shift1_r);
		end
	end

	// Bus slave: one wait cycle, write takes effect when waitrequest is low
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
			intfrac_r <= `FRNM_REG_RST;
			lsbfrac_r <= `FRNM_REG_RST;
			rdiv_r <= `FRNM_REG_RST;
			func_r <= `FRNM_REG_RST;
			test_r <= `FRNM_REG_RST;
			delay_r <= `FRNM_REG_RST;
			hop0_r <= 16'h0000;
			hop1_r <= 16'h0000;
			shift0_r <= 4'h0;
			shift1_r <= 4'h0;
			steps0_r <= 20'h00000;
			steps1_r <= 20'h00000;
			start_r <= 1'b0;
		end else begin
			start_r <= 1'b0;
			if (req && avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				if (avs_read)
					avs_readdata <= rd_nxt;
			end else begin
				avs_waitrequest <= 1'b1;
				if (req && avs_write) begin
					case (idx)
						`FRNM_IDX_INTFRAC: begin
							intfrac_r <= avs_writedata;
							start_r <= avs_writedata[`FRNM_RAMP_ON_BIT];
						end
						`FRNM_IDX_LSBFRAC: lsbfrac_r <= avs_writedata;
						`FRNM_IDX_RDIV: rdiv_r <= avs_writedata;
						`FRNM_IDX_FUNC: func_r <= avs_writedata;
						`FRNM_IDX_TEST: test_r <= avs_writedata;
						`FRNM_IDX_DEVI: begin
							if (avs_writedata[`FRNM_SET_BIT]) begin
								hop1_r <= avs_writedata[`FRNM_HOP_MSB:`FRNM_HOP_LSB];
								shift1_r <= avs_writedata[`FRNM_SHIFT_MSB:`FRNM_SHIFT_LSB];
							end else begin
								hop0_r <= avs_writedata[`FRNM_HOP_MSB:`FRNM_HOP_LSB];
								shift0_r <= avs_writedata[`FRNM_SHIFT_MSB:`FRNM_SHIFT_LSB];
							end
						end
						`FRNM_IDX_STEP: begin
							if (avs_writedata[`FRNM_SET_BIT])
								steps1_r <= avs_writedata[`FRNM_STEPS_MSB:`FRNM_STEPS_LSB];
							else
								steps0_r <= avs_writedata[`FRNM_STEPS_MSB:`FRNM_STEPS_LSB];
						end
						`FRNM_IDX_DELAY: delay_r <= avs_writedata;
						default: begin
						end
					endcase
				end
			end
		end
	end

	// Pin synchronisers
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			ref_s <= 3'h0;
			mod_s <= 3'h0;
			slip_s <= 3'h0;
			pass_s <= 3'h0;
			ref_d <= 1'b0;
			slip_d <= 1'b0;
			pass_d <= 1'b0;
		end else begin
			ref_s <= {ref_s[1:0], ref_in};
			mod_s <= {mod_s[1:0], mod_data};
			slip_s <= {slip_s[1:0], slip_imminent};
			pass_s <= {pass_s[1:0], freq_passed};
			ref_d <= ref_s[2];
			// Slip and overshoot edges judged from tick to tick
			if (pc_en) begin
				slip_d <= slip_s[2];
				pass_d <= pass_s[2];
			end
		end
	end

	// Reference divider producing the comparison enable
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			rcnt_r <= 12'h000;
			halve_t <= 1'b0;
			pc_tick <= 1'b0;
		end else begin
			pc_tick <= pc_en;
			if (ref_edge) begin
				if (rcnt_r >= rdiv - 12'h001) begin
					rcnt_r <= 12'h000;
					halve_t <= ~halve_t;
				end else begin
					rcnt_r <= rcnt_r + 12'h001;
				end
			end
		end
	end

	// Slip reduction cell sequencing, one decision per comparison period
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			cells <= 3'h0;
			overshoot <= 1'b0;
			slip_cells <= 7'h00;
		end else begin
			slip_cells <= (7'h01 << cells) - 7'h01;
			if (!slip_en) begin
				cells <= 3'h0;
				overshoot <= 1'b0;
			end else if (pc_en) begin
				if (pass_s[2] & ~pass_d & (cells != 3'h0))
					overshoot <= 1'b1;
				if (overshoot) begin
					if (cells != 3'h0)
						cells <= cells - 3'h1;
					else
						overshoot <= 1'b0;
				end else if (slip_s[2] & ~slip_d & (cells != `FRNM_SLIP_MAX)) begin
					cells <= cells + 3'h1;
				end
			end
		end
	end

	// Ramp engine
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			acc <= 41'h00000000000;
			cnt_a <= 12'h000;
			cnt_b <= 12'h000;
			step_cnt <= 20'h00000;
			dir_down <= 1'b0;
			ramp_active <= 1'b0;
			div_int <= 16'h0000;
			div_frac <= 25'h0000000;
			phase_flip <= 1'b0;
		end else begin
			div_int <= out_nxt[40:25];
			div_frac <= out_nxt[24:0];
			phase_flip <= func_r[`FRNM_PSK_BIT] & mod_s[2];
			ramp_active <= (state == ST_RUN) || (state == ST_RESTORE);
			if (pc_en) begin
				if (hop_due) begin
					cnt_a <= 12'h000;
					cnt_b <= 12'h000;
				end else if (cnt_a == nz12(rdiv_r[`FRNM_DIVA_MSB:`FRNM_DIVA_LSB]) - 12'h001) begin
					cnt_a <= 12'h000;
					cnt_b <= cnt_b + 12'h001;
				end else begin
					cnt_a <= cnt_a + 12'h001;
				end
			end
			if (!intfrac_r[`FRNM_RAMP_ON_BIT]) begin
				state <= ST_IDLE;
				acc <= base;
			end else if (start_r) begin
				state <= ST_RUN;
				acc <= base;
				cnt_a <= 12'h000;
				cnt_b <= 12'h000;
				step_cnt <= 20'h00000;
				dir_down <= 1'b0;
			end else begin
				case (state)
					ST_IDLE: acc <= base;
					ST_RUN: begin
						if (hop_due) begin
							if (dir_down)
								acc <= acc - hop_ext(hop0_r, shift0_r);
							else
								acc <= acc + hop_ext(hop0_r, shift0_r);
							step_cnt <= step_cnt + 20'h00001;
							if (step_cnt + 20'h00001 >= leg_steps) begin
								step_cnt <= 20'h00000;
								case (mode)
									`FRNM_MODE_BURST: state <= ST_HOLD;
									`FRNM_MODE_TRI: dir_down <= ~dir_down;
									default: state <= ST_RESTORE;
								endcase
							end
						end
					end
					ST_RESTORE: begin
						if (hop_due) begin
							acc <= base;
							if (mode == `FRNM_MODE_SAWREP)
								state <= ST_RUN;
							else
								state <= ST_HOLD;
						end
					end
					ST_HOLD: begin
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// ---- hw/frnm_map.vh ----
// Register offsets, field positions and reset values of the ramp modulator
`ifndef FRNM_MAP_VH
`define FRNM_MAP_VH

// Word indexes (byte address = index * 4)
`define FRNM_IDX_INTFRAC 4'h0
`define FRNM_IDX_LSBFRAC 4'h1
`define FRNM_IDX_RDIV 4'h2
`define FRNM_IDX_FUNC 4'h3
`define FRNM_IDX_TEST 4'h4
`define FRNM_IDX_DEVI 4'h5
`define FRNM_IDX_STEP 4'h6
`define FRNM_IDX_DELAY 4'h7
`define FRNM_IDX_STAT_FRAC 4'h8
`define FRNM_IDX_STAT_INT 4'h9
`define FRNM_IDX_STAT_MISC 4'hA

// Integer/upper fraction word
`define FRNM_RAMP_ON_BIT 31
`define FRNM_INT_MSB 30
`define FRNM_INT_LSB 15
`define FRNM_FMSB_MSB 14
`define FRNM_FMSB_LSB 3
// Lower fraction word
`define FRNM_FLSB_MSB 27
`define FRNM_FLSB_LSB 15
// Reference divider word
`define FRNM_SLIP_EN_BIT 28
`define FRNM_HALVE_BIT 21
`define FRNM_DOUBLE_BIT 20
`define FRNM_RCNT_MSB 19
`define FRNM_RCNT_LSB 15
`define FRNM_DIVA_MSB 14
`define FRNM_DIVA_LSB 3
// Function word
`define FRNM_MODE_MSB 11
`define FRNM_MODE_LSB 10
`define FRNM_PSK_BIT 9
`define FRNM_FSK_BIT 8
`define FRNM_POL_BIT 6
// Test word
`define FRNM_DIVB_MSB 18
`define FRNM_DIVB_LSB 7
// Deviation word
`define FRNM_SET_BIT 23
`define FRNM_SHIFT_MSB 22
`define FRNM_SHIFT_LSB 19
`define FRNM_HOP_MSB 18
`define FRNM_HOP_LSB 3
// Step word
`define FRNM_STEPS_MSB 22
`define FRNM_STEPS_LSB 3

// Waveform shapes
`define FRNM_MODE_BURST 2'h0
`define FRNM_MODE_SAW1 2'h1
`define FRNM_MODE_SAWREP 2'h2
`define FRNM_MODE_TRI 2'h3

`define FRNM_REG_RST 32'h00000000
`define FRNM_SLIP_MAX 3'h7

`endif

// ---- sim/frnm_core_sva.sv ----
// Port assertions for the ramp modulator core
`timescale 1ns/1ps
`default_nettype none
module frnm_core_sva (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register bus
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Outputs
	input wire logic [24:0] div_frac,
	input wire logic [6:0] slip_cells,
	input wire logic pc_tick,
	input wire logic ramp_active
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	// Hop seen while running, clear of recent writes
	sequence s_hop;
		$changed(div_frac) && ramp_active && $past(ramp_active, 2) && !$past(avs_write)
			&& !$past(avs_write, 2) && !$past(avs_write, 3);
	endsequence
	a_bus_answer: assert property (s_req |=> !avs_waitrequest)
		else $error("no answer one cycle after request");
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_wait_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("waitrequest low without request");
	a_read_hold: assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
		else $error("readdata changed outside a read");
	a_cells_thermo: assert property ((slip_cells & (slip_cells + 7'h01)) == 7'h00)
		else $error("cells not a thermometer code");
	a_cells_step: assert property ($changed(slip_cells) |->
		slip_cells == {$past(slip_cells[5:0]), 1'b1} || slip_cells == $past(slip_cells) >> 1)
		else $error("cells moved by more than one");
	a_hop_tick: assert property (s_hop |-> $past(pc_tick))
		else $error("hop not on a comparison tick");
	a_tick_pulse: assert property (pc_tick |=> !pc_tick)
		else $error("tick longer than one cycle");
endmodule
bind frnm_core frnm_core_sva chk (.mclk(mclk), .rst(rst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.div_frac(div_frac), .slip_cells(slip_cells), .pc_tick(pc_tick),
	.ramp_active(ramp_active));
`default_nettype wire

// ---- sim/frnm_host.sv ----
// Host model: bus master and start-up load
`timescale 1ns/1ps
`default_nettype none
module frnm_host (
	// Clock
	input wire logic mclk,
	// Avalon-MM master
	output logic [5:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	int stalls = 0;
	logic [31:0] rd_q;
	initial begin
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
	end
	task automatic xfer(input logic we, input logic [3:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= {idx, 2'b00};
		avs_writedata <= d;
		avs_write <= we;
		avs_read <= !we;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest);
		// One wait state per transfer is the contract
		if (n != 2) stalls++;
		rd_q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic init();
		xfer(1'b1, 4'h7, 32'h00000000);
		xfer(1'b1, 4'h6, 32'h00000018);
		xfer(1'b1, 4'h6, 32'h00800018);
		xfer(1'b1, 4'h5, 32'h00100028);
		xfer(1'b1, 4'h5, 32'h00880038);
		xfer(1'b1, 4'h4, 32'h00000080);
		xfer(1'b1, 4'h3, 32'h00000040);
		xfer(1'b1, 4'h2, 32'h00000010);
		xfer(1'b1, 4'h1, 32'h00010000);
		xfer(1'b1, 4'h0, 32'h00320008);
	endtask
endmodule
`default_nettype wire

// ---- sim/frnm_core_test.sv ----
// Testbench for the ramp modulator core
`timescale 1ns/1ps
`default_nettype none
module frnm_core_test;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ref_in = 1'b0;
	logic mod_data = 1'b0;
	logic slip_imminent = 1'b0;
	logic freq_passed = 1'b0;
	wire [5:0] avs_address;
	wire avs_read, avs_write, avs_waitrequest, phase_flip, pc_tick, ramp_active;
	wire [31:0] avs_writedata, avs_readdata;
	wire [15:0] div_int;
	wire [24:0] div_frac;
	wire [6:0] slip_cells;
	wire [31:0] frac_w = {7'h00, div_frac};
	wire [31:0] cells_w = {25'h0, slip_cells};
	int error_cnt = 0;
	int checks_done = 0;
	logic [31:0] lo, hi;
	frnm_host hst (.mclk(mclk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	frnm_core dut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ref_in(ref_in), .mod_data(mod_data),
		.slip_imminent(slip_imminent), .freq_passed(freq_passed), .div_int(div_int),
		.div_frac(div_frac), .phase_flip(phase_flip), .slip_cells(slip_cells),
		.pc_tick(pc_tick), .ramp_active(ramp_active));
	always #5 mclk = ~mclk;
	// Reference pin, four clocks a period
	always begin
		repeat (2) @(posedge mclk);
		ref_in <= ~ref_in;
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic watch(input int n);
		lo = frac_w;
		hi = frac_w;
		repeat (n) begin
			@(posedge mclk);
			if (frac_w < lo) lo = frac_w;
			if (frac_w > hi) hi = frac_w;
		end
	endtask
	task automatic wait_hop(output int n);
		logic [31:0] v;
		v = frac_w;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (frac_w === v && n < 200);
	endtask
	task automatic t_bus();
		hst.xfer(1'b1, 4'hC, 32'hFFFFFFFF);
		hst.xfer(1'b0, 4'hC, 32'h00000000);
		check("unmapped", 32'h0, hst.rd_q);
		hst.xfer(1'b0, 4'h9, 32'h00000000);
		check("whole", 32'h64, hst.rd_q);
		check("whole pin", 32'h64, {16'h0000, div_int});
		check("fraction", 32'h2002, frac_w);
		$display("t_bus done");
	endtask
	task automatic t_shapes();
		for (int m = 0; m < 4; m++) begin
			hst.xfer(1'b1, 4'h3, 32'h40 | (m << 10));
			hst.xfer(1'b1, 4'h0, 32'h80320008);
			watch(200);
			check("top", 32'h203E, hi);
			check("bottom", 32'h2002, lo);
			check("active", {31'h0, m > 1}, {31'h0, ramp_active});
			if (m < 2) check("held", m ? 32'h2002 : 32'h203E, frac_w);
			hst.xfer(1'b1, 4'h0, 32'h00320008);
		end
		$display("t_shapes done");
	endtask
	task automatic t_timer();
		int n;
		hst.xfer(1'b1, 4'h4, 32'h00000100);
		hst.xfer(1'b1, 4'h3, 32'h00000840);
		for (int k = 0; k < 4; k++) begin
			hst.xfer(1'b1, 4'h2, 32'h18 | (k << 20));
			hst.xfer(1'b1, 4'h0, 32'h80320008);
			wait_hop(n);
			wait_hop(n);
			check("gap", (k == 1) ? 12 : (k == 2) ? 48 : 24, n);
			hst.xfer(1'b1, 4'h0, 32'h00320008);
		end
		hst.xfer(1'b1, 4'h4, 32'h00000080);
		hst.xfer(1'b1, 4'h2, 32'h00000010);
		$display("t_timer done");
	endtask
	task automatic t_keying();
		hst.xfer(1'b1, 4'h3, 32'h00000340);
		mod_data <= 1'b1;
		cyc(8);
		check("fsk up", 32'h2010, frac_w);
		check("psk up", 32'h1, {31'h0, phase_flip});
		mod_data <= 1'b0;
		cyc(8);
		check("fsk down", 32'h1FF4, frac_w);
		check("psk down", 32'h0, {31'h0, phase_flip});
		hst.xfer(1'b1, 4'h3, 32'h00000040);
		cyc(4);
		check("fsk off", 32'h2002, frac_w);
		$display("t_keying done");
	endtask
	task automatic pulse(input int n);
		repeat (n) begin
			slip_imminent <= 1'b1;
			cyc(12);
			slip_imminent <= 1'b0;
			cyc(12);
		end
	endtask
	task automatic t_slip();
		pulse(2);
		check("slip off", 32'h0, cells_w);
		hst.xfer(1'b1, 4'h2, 32'h10000010);
		pulse(1);
		check("one cell", 32'h01, cells_w);
		pulse(8);
		check("cell limit", 32'h7F, cells_w);
		freq_passed <= 1'b1;
		cyc(60);
		check("cells off", 32'h0, cells_w);
		freq_passed <= 1'b0;
		hst.xfer(1'b0, 4'hA, 32'h00000000);
		check("status", 32'h10, hst.rd_q);
		$display("t_slip done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		cyc(4);
		rst <= 1'b0;
		hst.init();
		t_bus();
		t_shapes();
		t_timer();
		t_keying();
		t_slip();
		check("stalls", 32'h0, hst.stalls);
		complete_run();
	end
	initial begin
		#200000;
		error_cnt++;
		complete_run();
	end
endmodule
`default_nettype wire
